// ### hw/sacc_pkg.sv
// Shared constants for the converter configuration and trigger control block
package sacc_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_PERIOD_PS     = 8000;      // 125 MHz system clock
  localparam int SLOW_TICK_FREQ_HZ = 1000;      // Nominal internal tick source
  // Cycles of the system clock per slow tick, rounded down
  localparam int SLOW_TICK_CYC =
    int'(64'd1000000000000 / (64'(SLOW_TICK_FREQ_HZ) * 64'(CLK_PERIOD_PS)));
  localparam int LOCAL_CLK_DIV     = 4;         // Local conversion clock divider

  // ****************************************
  // Conversion clock source codes
  // ****************************************
  localparam logic [1:0] CLKSRC_BUS   = 2'h0;   // Bus clock
  localparam logic [1:0] CLKSRC_HALF  = 2'h1;   // Bus clock divided by two
  localparam logic [1:0] CLKSRC_ALT   = 2'h2;   // Alternate input, not present
  localparam logic [1:0] CLKSRC_LOCAL = 2'h3;   // Local asynchronous clock

  // ****************************************
  // Channel select codes
  // ****************************************
  localparam logic [4:0] CH_PIN_LAST = 5'h0b;   // Last pin-connected channel
  localparam logic [4:0] CH_RESERVED = 5'h1c;   // Undefined result
  localparam logic [4:0] CH_REF_HIGH = 5'h1d;   // High reference, supply
  localparam logic [4:0] CH_REF_LOW  = 5'h1e;   // Low reference, ground
  localparam logic [4:0] CH_DISABLE  = 5'h1f;   // Module off, no input
  localparam int         NUM_PINS    = 12;      // Pin-connected channels
  localparam int         FIRST_EN_W  = 8;       // Width of first pin enable group
  localparam int         SECOND_EN_W = 4;       // Width of second pin enable group

  // ****************************************
  // Result layout
  // ****************************************
  localparam int         RES_W       = 10;      // Full resolution
  localparam logic [3:0] MSB_IDX     = 4'h9;    // First trial bit
  localparam logic [3:0] LSB_IDX_10  = 4'h0;    // Last trial bit, 10-bit mode
  localparam logic [3:0] LSB_IDX_8   = 4'h2;    // Last trial bit, 8-bit mode

  // ****************************************
  // Tick counter
  // ****************************************
  localparam int         TICK_CNT_W  = 10;      // Free-running counter width
  localparam logic [2:0] RATE_OFF    = 3'h0;    // Rate code that stops overflows
  localparam int         RATE_BASE   = 2;       // Log2 period offset of the rate code

  // Converter states
  typedef enum logic [1:0] {
    SACC_IDLE,
    SACC_ARMED,
    SACC_SAMPLE,
    SACC_CONVERT
  } sacc_state_t;

endpackage

// ### hw/sacc_tick_counter.sv
// Periodic tick counter that issues the hardware conversion trigger
`timescale 1ns/1ps
module sacc_tick_counter #(
  parameter int SLOW_DIV = sacc_pkg::SLOW_TICK_CYC  // Cycles per 1 kHz tick
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       ext_reference_clock,  // Pin-level reference clock
  input  wire logic       tick_source_ext,      // 1: reference clock, 0: 1 kHz
  input  wire logic [2:0] tick_rate_select,     // Overflow period code
  output logic            overflow_pulse        // One cycle per overflow
);

  // Refuse a divider the counter cannot serve
  if (SLOW_DIV < 2) begin : g_chk
    $error("SLOW_DIV must be at least 2");
  end

  logic [1:0]                     ref_sync_reg;  // Two-stage synchroniser
  logic                           ref_prev_reg;  // Last synchronised level
  logic [31:0]                    slow_cnt_reg;  // Internal 1 kHz divider
  logic                           slow_tick_reg; // Internal tick pulse
  logic [sacc_pkg::TICK_CNT_W-1:0] tick_cnt_reg; // Free-running count
  logic [sacc_pkg::TICK_CNT_W-1:0] tick_last;    // Terminal count
  logic                           tick_en;       // One input tick

  // ****************************************
  // Input ticks
  // ****************************************

  // Reference pin is foreign to this clock, so it is synchronised first
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ref_sync_reg <= 2'h0;
      ref_prev_reg <= 1'b0;
    end else begin
      ref_sync_reg <= {ref_sync_reg[0], ext_reference_clock};
      ref_prev_reg <= ref_sync_reg[1];
    end
  end

  // Internal slow source, derived from the system clock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      slow_cnt_reg  <= 32'h0;
      slow_tick_reg <= 1'b0;
    end else if (slow_cnt_reg == 32'(SLOW_DIV - 1)) begin
      slow_cnt_reg  <= 32'h0;
      slow_tick_reg <= 1'b1;
    end else begin
      slow_cnt_reg  <= slow_cnt_reg + 32'h1;
      slow_tick_reg <= 1'b0;
    end
  end

  // Rising edge of the reference, or the slow tick
  assign tick_en = tick_source_ext ? (ref_sync_reg[1] & ~ref_prev_reg) : slow_tick_reg;

  // Period is two to the power of code plus base input ticks
  assign tick_last = sacc_pkg::TICK_CNT_W'((1 << (32'(tick_rate_select) + sacc_pkg::RATE_BASE)) - 1);

  // ****************************************
  // Free-running counter
  // ****************************************

  // Counts freely, one pulse per overflow
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick_cnt_reg   <= '0;
      overflow_pulse <= 1'b0;
    end else if (tick_rate_select == sacc_pkg::RATE_OFF) begin
      tick_cnt_reg   <= '0;
      overflow_pulse <= 1'b0;
    end else if (tick_en && tick_cnt_reg >= tick_last) begin
      tick_cnt_reg   <= '0;
      overflow_pulse <= 1'b1;
    end else begin
      tick_cnt_reg   <= tick_cnt_reg + (tick_en ? 1'b1 : 1'b0);
      overflow_pulse <= 1'b0;
    end
  end

endmodule

// ### hw/sacc_top.sv
// Converter control: clock choice, triggers, channel decode, SAR sequencing
//
// Overview of operation
// RULE1 - Conversion clock: bus, half bus, local
// RULE2 - Alternate clock input absent, gives no clock
// RULE3 - Hardware trigger starts conversion on tick overflow
// RULE4 - Tick counter free-runs at selectable rate
// RULE5 - Tick clock: reference clock or 1 kHz
// RULE6 - Hardware trigger works in run, wait, stop
// RULE7 - Codes 0 to 11 select pins, each enabled
// RULE8 - Code 28 reserved; code 31 disables module
// RULE9 - Code 29 high reference, 30 low reference
// RULE10 - Only two pin enable groups exist
// RULE11 - Software sets both low-voltage bits for stop
// RULE12 - Linear successive approximation, ten bits
// RULE13 - Result right-justified, ten or eight bits
// RULE14 - Single or continuous; single returns to idle
// RULE15 - Done flag and optional completion interrupt
// RULE16 - Optional compare, less or greater-equal
// RULE17 - Up to 28 inputs via channel select
// RULE18 - Control write aborts and restarts unless all ones
// RULE19 - Done flag clears on write or low read
// RULE20 - Active flag set at start, cleared at end
// RULE21 - Overflow becomes one-cycle trigger pulse
`timescale 1ns/1ps
module sacc_top #(
  parameter int SLOW_DIV  = sacc_pkg::SLOW_TICK_CYC, // Cycles per 1 kHz tick
  parameter int LOCAL_DIV = sacc_pkg::LOCAL_CLK_DIV  // Local clock divider
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        sc1_write,
  input  wire logic [4:0]  channel_select,
  input  wire logic        continuous_enable,
  input  wire logic        done_int_enable,
  input  wire logic        hw_trigger_enable,
  input  wire logic        compare_enable,
  input  wire logic        compare_greater,
  input  wire logic [9:0]  compare_value,
  input  wire logic [1:0]  conv_clock_select,
  input  wire logic        resolution_10bit,
  input  wire logic [7:0]  pin_enable_reg_first,
  input  wire logic [3:0]  pin_enable_reg_second,
  input  wire logic        result_low_read,
  input  wire logic        tick_source_ext,
  input  wire logic [2:0]  tick_rate_select,
  input  wire logic        ext_reference_clock,
  input  wire logic        stop_mode,
  input  wire logic        lowvolt_detect_enable,
  input  wire logic        lowvolt_stop_enable,
  input  wire logic        comparator_in,
  output logic [9:0]       result_data,
  output logic             conversion_done_flag,
  output logic             conversion_active_flag,
  output logic             conv_irq,
  output logic [9:0]       dac_code,
  output logic [11:0]      pin_channel_sel,
  output logic             ref_high_sel,
  output logic             ref_low_sel,
  output logic             converter_on,
  output logic [11:0]      pin_analog_enable
);

  // Refuse a local divider the enable logic cannot serve
  if (LOCAL_DIV < 2) begin : g_chk
    $error("LOCAL_DIV must be at least 2");
  end

  // ****************************************
  // Declarations
  // ****************************************

  sacc_pkg::sacc_state_t state_reg;      // Converter sequence state
  logic [4:0]            chan_reg;       // Latched channel code
  logic                  cont_reg;       // Latched continuous mode
  logic                  ien_reg;        // Latched interrupt enable
  logic [3:0]            bit_idx_reg;    // Current trial bit
  logic [9:0]            trial_reg;      // Approximation register
  logic                  done_set;       // Completion that sets the flag
  logic                  half_reg;       // Half-rate toggle
  logic [7:0]            local_cnt_reg;  // Local clock divider
  logic                  conv_en_reg;    // One conversion clock edge
  logic [1:0]            comp_sync_reg;  // Comparator synchroniser
  logic [1:0]            settle_reg;     // Cycles until a trial shows
  logic                  trig_pulse;     // Tick overflow, one cycle
  logic                  run_ok;         // Converter may run in this mode
  logic                  conv_tick;      // Usable conversion clock edge
  logic                  start_sw;       // Write that starts at once
  logic                  keep_bit;       // Comparator says keep trial bit
  logic [3:0]            lsb_idx;        // Last trial bit for resolution
  logic [9:0]            final_code;     // Approximation after last trial
  logic [9:0]            formatted;      // Right-justified result
  logic [9:0]            cmp_ref;        // Compare value at resolution
  logic                  cmp_true;       // Compare outcome
  logic                  result_ok;      // Result may be stored

  // ****************************************
  // Periodic tick counter
  // ****************************************

  // Overflow arrives already as a single-cycle pulse on this clock
  sacc_tick_counter #(
    .SLOW_DIV (SLOW_DIV)
  ) u_tick (
    .clock               (clock),
    .rst                 (rst),
    .ext_reference_clock (ext_reference_clock),
    .tick_source_ext     (tick_source_ext),      // RULE5
    .tick_rate_select    (tick_rate_select),     // RULE4
    .overflow_pulse      (trig_pulse)            // RULE21
  );

  // ****************************************
  // Conversion clock selection
  // ****************************************

  // Local clock runs as a divided enable, no second domain is needed
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      local_cnt_reg <= 8'h0;
    end else if (local_cnt_reg == 8'(LOCAL_DIV - 1)) begin
      local_cnt_reg <= 8'h0;
    end else begin
      local_cnt_reg <= local_cnt_reg + 8'h1;
    end
  end

  // Half-rate toggle for the divided bus clock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      half_reg <= 1'b0;
    end else begin
      half_reg <= ~half_reg;
    end
  end

  // One enable per conversion clock edge of the chosen source
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      conv_en_reg <= 1'b0;
    end else begin
      case (conv_clock_select)
        sacc_pkg::CLKSRC_BUS:   conv_en_reg <= 1'b1;                    // RULE1
        sacc_pkg::CLKSRC_HALF:  conv_en_reg <= half_reg;                // RULE1
        sacc_pkg::CLKSRC_LOCAL: conv_en_reg <= (local_cnt_reg == 8'h0); // RULE1
        // Input not bonded out; a conversion here stalls forever
        sacc_pkg::CLKSRC_ALT:   conv_en_reg <= 1'b0;                    // RULE2
        default:                conv_en_reg <= 1'b0;
      endcase
    end
  end

  // Stop mode: only the local clock survives, and only with low-voltage
  // detection kept on by software
  assign run_ok = ~stop_mode
                | (lowvolt_detect_enable & lowvolt_stop_enable); // RULE11
  assign conv_tick = conv_en_reg & run_ok & (settle_reg == 2'h0)
                   & (~stop_mode | (conv_clock_select == sacc_pkg::CLKSRC_LOCAL));

  // ****************************************
  // Comparator input
  // ****************************************

  // Comparator is asynchronous; a trial or new routing shows through the drive
  // flop and synchroniser three cycles later, so decisions wait that long
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      comp_sync_reg <= 2'h0;
      settle_reg    <= 2'h3;
    end else begin
      comp_sync_reg <= {comp_sync_reg[0], comparator_in};
      settle_reg    <= (sc1_write || trig_pulse || conv_tick) ? 2'h3
                     : settle_reg - {1'b0, settle_reg != 2'h0}; // RULE12
    end
  end

  // ****************************************
  // Result arithmetic
  // ****************************************

  // Eight-bit mode stops two trials early
  assign lsb_idx = resolution_10bit ? sacc_pkg::LSB_IDX_10 : sacc_pkg::LSB_IDX_8;

  // High comparator means the input is at or above the trial code
  assign keep_bit = comp_sync_reg[1];

  // Drop the current trial bit when the input is below it
  always_comb begin
    final_code = trial_reg;
    if (!keep_bit) begin
      final_code[bit_idx_reg] = 1'b0;                    // RULE12
    end
  end

  // Right-justify in either format
  assign formatted = resolution_10bit ? final_code
                   : {2'h0, final_code[9:2]};             // RULE13

  // Compare at the same resolution as the result
  assign cmp_ref  = resolution_10bit ? compare_value : {2'h0, compare_value[7:0]};
  assign cmp_true = compare_greater ? (formatted >= cmp_ref)
                  : (formatted < cmp_ref);                // RULE16
  assign result_ok = ~compare_enable | cmp_true;          // RULE16

  // A software start happens only with the trigger off and a live channel
  assign start_sw = sc1_write & ~hw_trigger_enable
                  & (channel_select != sacc_pkg::CH_DISABLE);

  // ****************************************
  // Conversion sequence
  // ****************************************

  // Main sequencer; a control write always wins over the current step
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg              <= sacc_pkg::SACC_IDLE;
      chan_reg               <= sacc_pkg::CH_DISABLE;
      cont_reg               <= 1'b0;
      ien_reg                <= 1'b0;
      bit_idx_reg            <= sacc_pkg::MSB_IDX;
      trial_reg              <= 10'h0;
      conversion_active_flag <= 1'b0;
      done_set               <= 1'b0;
      result_data            <= 10'h0;
    end else begin
      done_set <= 1'b0;
      if (sc1_write) begin
        // Abort whatever runs and take the new setup
        chan_reg    <= channel_select;                   // RULE17
        cont_reg    <= continuous_enable;
        ien_reg     <= done_int_enable;
        bit_idx_reg <= sacc_pkg::MSB_IDX;
        trial_reg   <= 10'h0;
        if (channel_select == sacc_pkg::CH_DISABLE) begin
          state_reg              <= sacc_pkg::SACC_IDLE; // RULE8
          conversion_active_flag <= 1'b0;                // RULE20
        end else if (hw_trigger_enable) begin
          state_reg              <= sacc_pkg::SACC_ARMED;
          conversion_active_flag <= 1'b0;                // RULE20
        end else if (start_sw) begin
          state_reg              <= sacc_pkg::SACC_SAMPLE; // RULE18
          conversion_active_flag <= 1'b1;                // RULE20
        end
      end else begin
        case (state_reg)
          sacc_pkg::SACC_IDLE: conversion_active_flag <= 1'b0;
          sacc_pkg::SACC_ARMED: begin
            // Overflow pulses keep coming in every power mode
            if (trig_pulse && hw_trigger_enable) begin     // RULE3 RULE6
              state_reg              <= sacc_pkg::SACC_SAMPLE;
              conversion_active_flag <= 1'b1;             // RULE20
            end
          end
          sacc_pkg::SACC_SAMPLE: begin
            // One conversion clock for sampling, then the first trial
            if (conv_tick) begin
              state_reg   <= sacc_pkg::SACC_CONVERT;
              bit_idx_reg <= sacc_pkg::MSB_IDX;
              trial_reg   <= 10'h200;                     // RULE12
            end
          end
          sacc_pkg::SACC_CONVERT: begin
            if (conv_tick) begin
              if (bit_idx_reg == lsb_idx) begin
                // Last trial decided; store and flag unless the compare fails
                if (result_ok) begin
                  result_data <= formatted;               // RULE13
                  done_set    <= 1'b1;                    // RULE15
                end
                if (cont_reg) begin
                  state_reg <= hw_trigger_enable ? sacc_pkg::SACC_ARMED
                                                 : sacc_pkg::SACC_SAMPLE; // RULE14
                  conversion_active_flag <= ~hw_trigger_enable;
                end else begin
                  state_reg              <= sacc_pkg::SACC_IDLE; // RULE14
                  conversion_active_flag <= 1'b0;         // RULE20
                end
                trial_reg <= 10'h0;
              end else begin
                // Settle this bit, try the next lower one
                trial_reg <= final_code | (10'h1 << (bit_idx_reg - 4'h1)); // RULE12
                bit_idx_reg <= bit_idx_reg - 4'h1;
              end
            end
          end
          default: begin
            state_reg              <= sacc_pkg::SACC_IDLE;
            conversion_active_flag <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Done flag and interrupt
  // ****************************************

  // Completion in the same cycle as a clear keeps the flag set
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      conversion_done_flag <= 1'b0;
    end else if (done_set) begin
      conversion_done_flag <= 1'b1;                       // RULE15
    end else if (sc1_write || result_low_read) begin
      conversion_done_flag <= 1'b0;                       // RULE19
    end
  end

  // Interrupt follows the flag one cycle later, gated by the enable
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      conv_irq <= 1'b0;
    end else begin
      conv_irq <= conversion_done_flag & ien_reg;         // RULE15
    end
  end

  // ****************************************
  // Analog-side drive
  // ****************************************

  // Trial code for the capacitor array; zero outside a conversion
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dac_code <= 10'h0;
    end else begin
      dac_code <= trial_reg;                              // RULE12
    end
  end

  // Only two enable groups exist; nothing is reserved for a third
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_analog_enable <= 12'h0;
    end else begin
      pin_analog_enable <= {pin_enable_reg_second, pin_enable_reg_first}; // RULE10 RULE7
    end
  end

  // Input routing from the latched channel while the converter works;
  // codes between the last pin and the reserved code route nothing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_channel_sel <= 12'h0;
      ref_high_sel    <= 1'b0;
      ref_low_sel     <= 1'b0;
      converter_on    <= 1'b0;
    end else begin
      pin_channel_sel <= 12'h0;
      ref_high_sel    <= 1'b0;
      ref_low_sel     <= 1'b0;
      // Powered only while sampling or converting, low power otherwise
      converter_on    <= conversion_active_flag
                       && chan_reg != sacc_pkg::CH_DISABLE; // RULE8
      if (conversion_active_flag) begin
        if (chan_reg <= sacc_pkg::CH_PIN_LAST) begin
          pin_channel_sel <= 12'h1 << chan_reg;           // RULE7
        end else if (chan_reg == sacc_pkg::CH_REF_HIGH) begin
          ref_high_sel <= 1'b1;                           // RULE9
        end else if (chan_reg == sacc_pkg::CH_REF_LOW) begin
          ref_low_sel <= 1'b1;                            // RULE9
        end
        // Reserved code connects nothing; its result is meaningless
      end
    end
  end

endmodule

// ### test/sacc_analog_model.sv
// Analog side model: reference levels, pin levels and reference clock
`timescale 1ns/1ps
module sacc_analog_model (
  input  wire logic        clock,
  input  wire logic [9:0]  dac_code,
  input  wire logic [11:0] pin_channel_sel,
  input  wire logic        ref_high_sel,
  output logic             comparator_in,
  output logic             ext_reference_clock
);
  logic [1:0] div_reg = 2'h0; // Reference clock divider, runs free
  // Supply beats every trial; ground and pins sit at zero scale
  assign comparator_in = ref_high_sel | ((|pin_channel_sel) & (dac_code == 10'h000));
  // Reference clock at a quarter of the system rate
  always_ff @(posedge clock) div_reg <= div_reg + 2'h1;
  assign ext_reference_clock = div_reg[1];
endmodule

// ### test/sacc_top_sva.sv
// Assertion checker for the converter control block
`timescale 1ns/1ps
module sacc_top_sva (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        sc1_write,
  input wire logic [4:0]  channel_select,
  input wire logic        hw_trigger_enable,
  input wire logic        continuous_enable,
  input wire logic [7:0]  pin_enable_reg_first,
  input wire logic [3:0]  pin_enable_reg_second,
  input wire logic        conversion_done_flag,
  input wire logic        conversion_active_flag,
  input wire logic        conv_irq,
  input wire logic [11:0] pin_channel_sel,
  input wire logic        ref_high_sel,
  input wire logic        ref_low_sel,
  input wire logic [11:0] pin_analog_enable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_pin_enable_copy: assert property (
    pin_analog_enable == $past({pin_enable_reg_second, pin_enable_reg_first}))
    else $error("pin enable copy wrong");
  a_write_starts: assert property (
    sc1_write && channel_select != 5'h1f && !hw_trigger_enable |=> conversion_active_flag)
    else $error("write did not start");
  a_write_off: assert property (
    sc1_write && channel_select == 5'h1f |=> !conversion_active_flag)
    else $error("disable code started");
  a_write_arms: assert property (
    sc1_write && hw_trigger_enable |=> !conversion_active_flag)
    else $error("armed write started");
  a_write_clears: assert property (
    sc1_write |=> !conversion_done_flag)
    else $error("done kept after write");
  a_irq_lags: assert property (
    conv_irq |-> $past(conversion_done_flag))
    else $error("irq without done");
  a_ref_alone: assert property (
    ref_high_sel |-> !ref_low_sel && pin_channel_sel == 12'h000)
    else $error("two inputs routed");
  a_single_idle: assert property (
    $rose(conversion_done_flag) && !continuous_enable |-> !conversion_active_flag)
    else $error("single did not idle");
  c_done: cover property ($rose(conversion_done_flag));
  c_irq: cover property (conv_irq);
  c_arm: cover property (sc1_write && hw_trigger_enable);
endmodule
bind sacc_top sacc_top_sva sacc_top_sva_i (.*);

// ### test/sacc_top_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module sacc_top_tb;
  logic clock = 1'b0, rst = 1'b1, sc1_write = 1'b0, continuous_enable = 1'b0;
  logic done_int_enable = 1'b0, hw_trigger_enable = 1'b0, compare_enable = 1'b0;
  logic compare_greater = 1'b0, resolution_10bit = 1'b1, result_low_read = 1'b0;
  logic tick_source_ext = 1'b1, stop_mode = 1'b0, lowvolt_detect_enable = 1'b0;
  logic lowvolt_stop_enable = 1'b0, comparator_in, ext_reference_clock, done_prev = 1'b0;
  logic conversion_done_flag, conversion_active_flag, conv_irq, ref_high_sel, ref_low_sel;
  logic converter_on;
  logic [4:0]  channel_select = 5'h00;
  logic [1:0]  conv_clock_select = 2'h0;
  logic [2:0]  tick_rate_select = 3'h1;
  logic [7:0]  pin_enable_reg_first = 8'h00;
  logic [3:0]  pin_enable_reg_second = 4'h0;
  logic [9:0]  compare_value = 10'h3ff, result_data, dac_code, exp_q[$];
  logic [11:0] pin_channel_sel, pin_analog_enable;
  logic [31:0] seed = 32'h1c; // Fixed xorshift seed
  int          n_errors = 0, num_checks = 0, k, ch;
  sacc_top #(.SLOW_DIV(10)) sacc_top_i (.*);
  sacc_analog_model sacc_analog_model_i (.*);
  always #4 clock = ~clock;
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Control write, then two cycles for the registered selects to settle
  task automatic start(input logic [4:0] c);
    @(negedge clock);
    channel_select = c;
    sc1_write = 1'b1;
    @(negedge clock);
    sc1_write = 1'b0;
    repeat (2) @(negedge clock);
  endtask
  // Bounded wait; a missing expected completion ends the run
  task automatic wait_done(input logic hit);
    for (k = 0; k < 400 && conversion_done_flag !== 1'b1; k++) @(negedge clock);
    check(12'(conversion_done_flag), 12'(hit));
    if (hit && k == 400) complete_run();
  endtask
  // Each rising done flag takes the oldest note off the queue
  always @(negedge clock) begin
    if (conversion_done_flag === 1'b1 && done_prev !== 1'b1) begin
      if (exp_q.size() > 0) check(12'(result_data), 12'(exp_q.pop_front()));
      else check(12'h001, 12'h000);
    end
    done_prev <= conversion_done_flag;
  end
  initial begin
    repeat (5) @(negedge clock);
    rst = 1'b0;
    check(12'({result_data, conversion_done_flag, conversion_active_flag}), 12'h000);
    check(pin_channel_sel | pin_analog_enable, 12'h000);
    // Random pins and enables, each start aborted by the disable code
    repeat (4) begin
      seed = xorshift(seed);
      ch = seed[31:16] % 12;
      {pin_enable_reg_second, pin_enable_reg_first} = seed[11:0];
      start(5'(ch));
      check(pin_channel_sel, 12'h001 << ch);
      check(pin_analog_enable, seed[11:0]);
      start(5'h1f);
      check(12'({converter_on, conversion_active_flag}) | pin_channel_sel, 12'h000);
    end
    $display("end pins");
    // References over bus, half and local clocks at both widths
    for (ch = 0; ch < 6; ch++) begin
      conv_clock_select = (ch % 3 == 2) ? 2'h3 : 2'(ch % 3);
      resolution_10bit = (ch < 3);
      exp_q.push_back((ch % 2) ? 10'h000 : (resolution_10bit ? 10'h3ff : 10'h0ff));
      start((ch % 2) ? 5'h1e : 5'h1d);
      check(12'({ref_high_sel, ref_low_sel}), (ch % 2) ? 12'h001 : 12'h002);
      wait_done(1'b1);
      check(12'({dac_code, conversion_active_flag}), 12'h000);
    end
    $display("end refs");
    conv_clock_select = 2'h2;
    start(5'h1d);
    wait_done(1'b0);
    conv_clock_select = 2'h0;
    resolution_10bit = 1'b1;
    compare_enable = 1'b1;
    start(5'h1d);
    wait_done(1'b0);
    compare_greater = 1'b1;
    done_int_enable = 1'b1;
    exp_q.push_back(10'h3ff);
    start(5'h1d);
    wait_done(1'b1);
    @(negedge clock);
    check(12'(conv_irq), 12'h001);
    result_low_read = 1'b1;
    @(negedge clock);
    result_low_read = 1'b0;
    @(negedge clock);
    check(12'(conversion_done_flag), 12'h000);
    $display("end compare");
    // Tick trigger in stop mode on the local clock
    {compare_enable, hw_trigger_enable, stop_mode, conv_clock_select} = 5'h1f;
    {lowvolt_detect_enable, lowvolt_stop_enable} = 2'h3;
    repeat (2) begin
      exp_q.push_back(10'h3ff);
      start(5'h1d);
      wait_done(1'b1);
      tick_source_ext = 1'b0;
    end
    $display("end trigger");
    complete_run();
  end
endmodule
